/* hw/csp_defs.vh */
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH
// ahb-lite register map, byte addresses on the low address bits
`define CSP_ADDR_W 8
`define CSP_OFF_SUPPLY 8'h00
`define CSP_OFF_ADC 8'h04
`define CSP_OFF_PWM 8'h08
`define CSP_OFF_WDOG 8'h0c
`define CSP_OFF_DRIVE 8'h10
`define CSP_OFF_CSAMP 8'h14
`define CSP_OFF_STATUS 8'h18
`define CSP_OFF_CTRL 8'h1c
// supply: gate_supply_setpoint [1:0], buck_switching_frequency [3:2]
`define CSP_SUP_W 4
`define CSP_SUP_RST 4'h0
// adc: request [0], input select [3:1], filter enable [4]
`define CSP_ADC_W 5
`define CSP_ADC_RST 5'h00
// pwm: mode [2:0], pwm_recirculation [3]
`define CSP_PWM_W 4
`define CSP_PWM_RST 4'h0
// watchdog standby part: enable [0], input select [1], fault config [3:2],
// timeout [6:4], brake select [7], latch enable [8], restart [10:9]
`define CSP_WDS_W 11
`define CSP_WDS_RST 11'h000
// locked rotor part of the watchdog word: enable [11], time [14:12]
`define CSP_RLK_W 4
`define CSP_RLK_RST 4'h0
// drive: gate currents [7:0], drive timing [15:8],
// deadtime_rising [19:16], deadtime_falling [23:20]
`define CSP_DRV_W 24
`define CSP_DRV_RST 24'h000000
// csamp: gain [2:0], blanking [4:3], positive threshold [7:5],
// negative threshold [10:8], sense_gain_analog_select [11]
`define CSP_CSA_W 11
`define CSP_CSA_RST 11'h000
`define CSP_ANA_BIT 11
// one-time-memory start-up settings
`define CSP_OTP_W 8
// status: state [2:0], drive enable [3], otp start-up settings [15:8]
`define CSP_ST_W 3
`define CSP_ST_DRV_BIT 3
`define CSP_ST_OTP_LSB 8
// ctrl: defer drive word to pwm or brake event [0]
`define CSP_CTRL_DEFER_BIT 0
`endif

/* hw/csp_shadow_reg.v */
`timescale 1ns/1ns
// held copy that software sees, effective copy that the logic uses
module csp_shadow_reg #(
  parameter W = 4,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire hclk,
  input wire hresetn,
  input wire wr_en,
  input wire [W-1:0] wr_data,
  input wire load,
  output reg [W-1:0] held,
  output reg [W-1:0] eff
);
  // a write shows in the held copy at once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held <= RST;
    end else if (wr_en) begin
      held <= wr_data;
    end
  end

  // transfer only when allowed; a write in the same cycle lands next load
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eff <= RST;
    end else if (load) begin
      eff <= held;
    end
  end
endmodule

/* hw/csp_ahb_slave.v */
`timescale 1ns/1ns
`include "csp_defs.vh"
// ahb-lite front end: zero-wait writes, one wait state on reads
module csp_ahb_slave (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  output reg hreadyout,
  output wire wr_pulse,
  output wire rd_pulse,
  output reg [`CSP_ADDR_W-1:0] ph_addr,
  output reg ph_map
);
  reg ph_wr;
  reg ph_rd;
  wire accept;

  // nonseq or seq with the bus ready starts a transfer
  assign accept = hsel & htrans[1] & hready;
  assign wr_pulse = ph_wr & ph_map;
  // reads sample registers in the wait cycle so a write just before is seen
  assign rd_pulse = ph_rd & ~hreadyout;

  // capture the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= {`CSP_ADDR_W{1'b0}};
      ph_map <= 1'b0;
    end else if (hready) begin
      ph_wr <= accept & hwrite;
      ph_rd <= accept & ~hwrite;
      ph_addr <= haddr[`CSP_ADDR_W-1:0];
      ph_map <= (haddr[31:`CSP_ADDR_W] == {(32-`CSP_ADDR_W){1'b0}});
    end
  end

  // one low cycle after each accepted read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= ~(accept & ~hwrite);
    end
  end
endmodule

/* hw/csp_config_shadow.v */
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "csp_defs.vh"
// How it works
// RULE_01 - writes accepted at any time, every category
// RULE_02 - always fields apply right after write
// RULE_03 - drive word may wait for pwm/brake
// RULE_04 - standby fields act only while enable low
// RULE_05 - standby write readable at once, old kept
// RULE_06 - copy pending values on entering standby
// RULE_07 - host writes standby fields before enabling drive
// RULE_08 - otp fields used only from power-up capture
// RULE_09 - register writes never change start-up settings
// RULE_10 - adc request, select, filter: register only
// RULE_11 - gain and blanking immediate; host stops pwm
// RULE_12 - analog select: digital in standby, analog otp
// RULE_13 - enable falling in active: pumps off, standby
// RULE_14 - watchdog, pwm, supply fields are standby
// RULE_15 - drive, deadtime, thresholds, locked rotor immediate
module csp_config_shadow (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output reg hresp,
  input wire drive_enable_input,
  input wire cp_target_reached,
  input wire pwm_event,
  input wire brake_event,
  input wire [`CSP_OTP_W-1:0] otp_startup_settings,
  input wire otp_sense_analog,
  output wire [`CSP_SUP_W-1:0] eff_supply,
  output wire [`CSP_ADC_W-1:0] eff_adc,
  output wire [`CSP_PWM_W-1:0] eff_pwm,
  output wire [`CSP_WDS_W-1:0] eff_watchdog,
  output wire [`CSP_RLK_W-1:0] eff_locked_rotor,
  output wire [`CSP_DRV_W-1:0] eff_drive,
  output wire [`CSP_CSA_W-1:0] eff_csamp,
  output reg eff_sense_analog,
  output reg [`CSP_OTP_W-1:0] eff_otp_startup,
  output reg charge_pump_enable,
  output reg pwm_path_enable
);
  // one-hot states of the gate driver sequence
  localparam [2:0] ST_STANDBY = 3'h1;
  localparam [2:0] ST_PUMP_START = 3'h2;
  localparam [2:0] ST_ACTIVE = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg defer_drive;
  reg otp_taken;
  reg ana_held;
  wire wr_pulse;
  wire rd_pulse;
  wire [`CSP_ADDR_W-1:0] ph_addr;
  wire ph_map;
  wire standby_load;
  wire drive_load;
  wire [`CSP_SUP_W-1:0] sup_held;
  wire [`CSP_ADC_W-1:0] adc_held;
  wire [`CSP_PWM_W-1:0] pwm_held;
  wire [`CSP_WDS_W-1:0] wds_held;
  wire [`CSP_RLK_W-1:0] rlk_held;
  wire [`CSP_DRV_W-1:0] drv_held;
  wire [`CSP_CSA_W-1:0] csa_held;
  reg [31:0] next_rdata;

  // write decode, shared by every register
  function reg_hit;
    input [`CSP_ADDR_W-1:0] addr;
    input [`CSP_ADDR_W-1:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // bus front end; hsize is not checked, only whole words are expected
  csp_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .wr_pulse(wr_pulse),
    .rd_pulse(rd_pulse),
    .ph_addr(ph_addr),
    .ph_map(ph_map)
  );

  // slave always answers okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // sequence: standby, charge pumps starting, active
  always @* begin
    next_state = state;
    case (state)
      ST_STANDBY: begin
        if (drive_enable_input) begin
          next_state = ST_PUMP_START;
        end
      end
      ST_PUMP_START: begin
        if (!drive_enable_input) begin
          next_state = ST_STANDBY;
        end else if (cp_target_reached) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // RULE_13 enable low: standby
        if (!drive_enable_input) begin
          next_state = ST_STANDBY;
        end
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase
  end

  // state and the driver controls it implies, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_STANDBY;
      charge_pump_enable <= 1'b0;
      pwm_path_enable <= 1'b0;
    end else begin
      state <= next_state;
      // RULE_13 pumps and pwm off
      charge_pump_enable <= (next_state != ST_STANDBY);
      pwm_path_enable <= (next_state == ST_ACTIVE);
    end
  end

  // standby transfer: only in standby and with enable low, so a quick
  // re-enable never lets a half-changed setting reach the running driver
  // RULE_04 enable low gate
  // RULE_06 standby entry transfer
  assign standby_load = (state == ST_STANDBY) & ~drive_enable_input;

  // drive word follows at once, or waits for a pwm or braking edge
  // RULE_03 optional event alignment
  assign drive_load = ~defer_drive | pwm_event | brake_event;

  // control word: the defer choice for the drive settings
  // RULE_01 writes any state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      defer_drive <= 1'b0;
    end else if (wr_pulse & reg_hit(ph_addr, `CSP_OFF_CTRL)) begin
      defer_drive <= hwdata[`CSP_CTRL_DEFER_BIT];
    end
  end

  // supply setpoint and buck frequency wait for standby
  // RULE_14 supply standby class
  // RULE_05 held copy readable
  csp_shadow_reg #(
    .W(`CSP_SUP_W),
    .RST(`CSP_SUP_RST)
  ) u_supply (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_pulse & reg_hit(ph_addr, `CSP_OFF_SUPPLY)),
    .wr_data(hwdata[`CSP_SUP_W-1:0]),
    .load(standby_load),
    .held(sup_held),
    .eff(eff_supply)
  );

  // adc fields live only here, no one-time copy exists for them
  // RULE_10 adc register only
  csp_shadow_reg #(
    .W(`CSP_ADC_W),
    .RST(`CSP_ADC_RST)
  ) u_adc (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_pulse & reg_hit(ph_addr, `CSP_OFF_ADC)),
    .wr_data(hwdata[`CSP_ADC_W-1:0]),
    .load(1'b1),
    .held(adc_held),
    .eff(eff_adc)
  );

  // pwm mode and recirculation wait for standby
  // RULE_14 pwm standby class
  csp_shadow_reg #(
    .W(`CSP_PWM_W),
    .RST(`CSP_PWM_RST)
  ) u_pwm (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_pulse & reg_hit(ph_addr, `CSP_OFF_PWM)),
    .wr_data(hwdata[`CSP_PWM_W-1:0]),
    .load(standby_load),
    .held(pwm_held),
    .eff(eff_pwm)
  );

  // watchdog word, low part: standby class
  // RULE_14 watchdog standby class
  csp_shadow_reg #(
    .W(`CSP_WDS_W),
    .RST(`CSP_WDS_RST)
  ) u_wdog (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_pulse & reg_hit(ph_addr, `CSP_OFF_WDOG)),
    .wr_data(hwdata[`CSP_WDS_W-1:0]),
    .load(standby_load),
    .held(wds_held),
    .eff(eff_watchdog)
  );

  // same word, high part: locked rotor settings act at once
  // RULE_15 locked rotor immediate
  csp_shadow_reg #(
    .W(`CSP_RLK_W),
    .RST(`CSP_RLK_RST)
  ) u_rlock (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_pulse & reg_hit(ph_addr, `CSP_OFF_WDOG)),
    .wr_data(hwdata[`CSP_WDS_W+`CSP_RLK_W-1:`CSP_WDS_W]),
    .load(1'b1),
    .held(rlk_held),
    .eff(eff_locked_rotor)
  );

  // gate currents, timing and dead time
  // RULE_02 immediate apply
  // RULE_15 drive immediate class
  csp_shadow_reg #(
    .W(`CSP_DRV_W),
    .RST(`CSP_DRV_RST)
  ) u_drive (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_pulse & reg_hit(ph_addr, `CSP_OFF_DRIVE)),
    .wr_data(hwdata[`CSP_DRV_W-1:0]),
    .load(drive_load),
    .held(drv_held),
    .eff(eff_drive)
  );

  // gain, blanking and thresholds act at once; changing gain or
  // blanking under pwm can glitch the sense path, software stops pwm
  // RULE_11 gain blank immediate
  csp_shadow_reg #(
    .W(`CSP_CSA_W),
    .RST(`CSP_CSA_RST)
  ) u_csamp (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_pulse & reg_hit(ph_addr, `CSP_OFF_CSAMP)),
    .wr_data(hwdata[`CSP_CSA_W-1:0]),
    .load(1'b1),
    .held(csa_held),
    .eff(eff_csamp)
  );

  // start-up settings are caught once after reset release; no write
  // path reaches them, they change only with a new power-up
  // RULE_08 otp capture once
  // RULE_09 no write path
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otp_taken <= 1'b0;
      eff_otp_startup <= {`CSP_OTP_W{1'b0}};
    end else if (!otp_taken) begin
      otp_taken <= 1'b1;
      eff_otp_startup <= otp_startup_settings;
    end
  end

  // analog select: only a clear to digital is taken from software;
  // analog can come only from the one-time memory at start-up
  // RULE_12 digital only write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ana_held <= 1'b0;
    end else if (!otp_taken) begin
      ana_held <= otp_sense_analog;
    end else if (wr_pulse & reg_hit(ph_addr, `CSP_OFF_CSAMP)) begin
      ana_held <= ana_held & hwdata[`CSP_ANA_BIT];
    end
  end

  // the digital choice is a standby setting
  // RULE_12 standby transfer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eff_sense_analog <= 1'b0;
    end else if (!otp_taken) begin
      eff_sense_analog <= otp_sense_analog;
    end else if (standby_load) begin
      eff_sense_analog <= ana_held;
    end
  end

  // read mux returns held copies, so a pending value reads back at once
  // RULE_05 read shows written
  always @* begin
    next_rdata = 32'h00000000;
    if (ph_map) begin
      case (ph_addr)
        `CSP_OFF_SUPPLY: begin
          next_rdata[`CSP_SUP_W-1:0] = sup_held;
        end
        `CSP_OFF_ADC: begin
          next_rdata[`CSP_ADC_W-1:0] = adc_held;
        end
        `CSP_OFF_PWM: begin
          next_rdata[`CSP_PWM_W-1:0] = pwm_held;
        end
        `CSP_OFF_WDOG: begin
          next_rdata[`CSP_WDS_W-1:0] = wds_held;
          next_rdata[`CSP_WDS_W+`CSP_RLK_W-1:`CSP_WDS_W] = rlk_held;
        end
        `CSP_OFF_DRIVE: begin
          next_rdata[`CSP_DRV_W-1:0] = drv_held;
        end
        `CSP_OFF_CSAMP: begin
          next_rdata[`CSP_CSA_W-1:0] = csa_held;
          next_rdata[`CSP_ANA_BIT] = ana_held;
        end
        `CSP_OFF_STATUS: begin
          next_rdata[`CSP_ST_W-1:0] = state;
          next_rdata[`CSP_ST_DRV_BIT] = drive_enable_input;
          next_rdata[`CSP_ST_OTP_LSB+`CSP_OTP_W-1:`CSP_ST_OTP_LSB] = eff_otp_startup;
        end
        `CSP_OFF_CTRL: begin
          next_rdata[`CSP_CTRL_DEFER_BIT] = defer_drive;
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // read data is loaded in the wait cycle and held until the next read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pulse) begin
      hrdata <= next_rdata;
    end
  end
endmodule

/* verification/csp_config_shadow_props.sv */
`timescale 1ns/1ns
`include "csp_defs.vh"
// watches the top ports only; every check is quiet while reset is low
module csp_config_shadow_props (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire drive_enable_input,
  input wire [`CSP_OTP_W-1:0] otp_startup_settings,
  input wire [`CSP_SUP_W-1:0] eff_supply,
  input wire [`CSP_ADC_W-1:0] eff_adc,
  input wire [`CSP_PWM_W-1:0] eff_pwm,
  input wire [`CSP_WDS_W-1:0] eff_watchdog,
  input wire [`CSP_RLK_W-1:0] eff_locked_rotor,
  input wire eff_sense_analog,
  input wire [`CSP_OTP_W-1:0] eff_otp_startup,
  input wire charge_pump_enable,
  input wire pwm_path_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // write address phase taken at this edge, and the immediate field slices
  wire wr_take = hsel && htrans[1] && hready && hwrite;
  wire [`CSP_ADC_W-1:0] wd_adc = hwdata[`CSP_ADC_W-1:0];
  wire [`CSP_RLK_W-1:0] wd_rlk = hwdata[14:11];

  property p_wr_nowait;
    wr_take |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_adc_now;
    wr_take && haddr == 32'(`CSP_OFF_ADC) |=> ##2 eff_adc == $past(wd_adc, 2);
  endproperty
  a_adc_now: assert property (p_adc_now) else $error("adc word late");
  property p_rlk_now;
    wr_take && haddr == 32'(`CSP_OFF_WDOG) |=> ##2 eff_locked_rotor == $past(wd_rlk, 2);
  endproperty
  a_rlk_now: assert property (p_rlk_now) else $error("locked rotor late");
  property p_stby_hold;
    $changed({eff_supply, eff_pwm, eff_watchdog}) |-> !$past(drive_enable_input);
  endproperty
  a_stby_hold: assert property (p_stby_hold) else $error("standby word moved");
  property p_drv_off;
    (!drive_enable_input) [*2] |=> !charge_pump_enable && !pwm_path_enable;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("pumps still on");
  property p_pwm_pump;
    pwm_path_enable |-> charge_pump_enable;
  endproperty
  a_pwm_pump: assert property (p_pwm_pump) else $error("pwm without pumps");
  property p_otp_cap;
    $rose(hresetn) |=> eff_otp_startup == $past(otp_startup_settings);
  endproperty
  a_otp_cap: assert property (p_otp_cap) else $error("start-up word not taken");
  property p_otp_keep;
    $past(hresetn, 2) |-> $stable(eff_otp_startup);
  endproperty
  a_otp_keep: assert property (p_otp_keep) else $error("start-up word moved");
  property p_ana_keep;
    $past(hresetn, 2) |-> !$rose(eff_sense_analog);
  endproperty
  a_ana_keep: assert property (p_ana_keep) else $error("analog select set");
endmodule

bind csp_config_shadow csp_config_shadow_props props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .drive_enable_input(drive_enable_input), .otp_startup_settings(otp_startup_settings),
  .eff_supply(eff_supply), .eff_adc(eff_adc), .eff_pwm(eff_pwm),
  .eff_watchdog(eff_watchdog), .eff_locked_rotor(eff_locked_rotor),
  .eff_sense_analog(eff_sense_analog), .eff_otp_startup(eff_otp_startup),
  .charge_pump_enable(charge_pump_enable), .pwm_path_enable(pwm_path_enable)
);

/* verification/csp_host_model.sv */
`timescale 1ns/1ns
// bus master standing in for the host controller; single whole words only
module csp_host_model (
  input wire hclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // each phase is held until hready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // released data lines flip so a stale word never looks fresh
    hwdata <= ~d;
  endtask
endmodule

/* verification/csp_config_shadow_tb.sv */
`timescale 1ns/1ns
`include "csp_defs.vh"
module csp_config_shadow_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic drive_enable_input = 1'b0;
  logic cp_target_reached = 1'b0;
  logic pwm_event = 1'b0;
  logic brake_event = 1'b0;
  logic [7:0] otp_startup_settings = 8'ha5;
  logic otp_sense_analog = 1'b1;
  logic [31:0] q;
  int errors = 0;
  int cmp_count = 0;
  wire hsel, hwrite, hreadyout, hresp, eff_sense_analog, charge_pump_enable, pwm_path_enable;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [`CSP_SUP_W-1:0] eff_supply;
  wire [`CSP_ADC_W-1:0] eff_adc;
  wire [`CSP_PWM_W-1:0] eff_pwm;
  wire [`CSP_WDS_W-1:0] eff_watchdog;
  wire [`CSP_RLK_W-1:0] eff_locked_rotor;
  wire [`CSP_DRV_W-1:0] eff_drive;
  wire [`CSP_CSA_W-1:0] eff_csamp;
  wire [7:0] eff_otp_startup;

  // 50 ns clock
  always #25 hclk = ~hclk;

  // hready is the slave's own hreadyout
  csp_config_shadow DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .drive_enable_input(drive_enable_input),
    .cp_target_reached(cp_target_reached), .pwm_event(pwm_event), .brake_event(brake_event),
    .otp_startup_settings(otp_startup_settings), .otp_sense_analog(otp_sense_analog),
    .eff_supply(eff_supply), .eff_adc(eff_adc), .eff_pwm(eff_pwm),
    .eff_watchdog(eff_watchdog), .eff_locked_rotor(eff_locked_rotor), .eff_drive(eff_drive),
    .eff_csamp(eff_csamp), .eff_sense_analog(eff_sense_analog),
    .eff_otp_startup(eff_otp_startup), .charge_pump_enable(charge_pump_enable),
    .pwm_path_enable(pwm_path_enable)
  );
  csp_host_model host (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
  );

  // shared helpers: compare, wait, bus access, drive enable, event pulse
  task chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task wr(input logic [31:0] a, d);
    host.xfer(1'b1, a, d, q);
    cyc(1);
  endtask
  task rd(input logic [31:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task drv(input logic v);
    @(posedge hclk);
    drive_enable_input <= v;
    cp_target_reached <= v;
    cyc(4);
  endtask
  task ev(input logic p, b);
    @(posedge hclk);
    pwm_event <= p;
    brake_event <= b;
    @(posedge hclk);
    pwm_event <= 1'b0;
    brake_event <= 1'b0;
    cyc(2);
  endtask

  task t_reset;
    chk(eff_otp_startup, 8'ha5);
    chk(eff_sense_analog, 1'b1);
    chk({eff_supply, eff_pwm, eff_watchdog}, 32'h0);
    rd(`CSP_OFF_STATUS);
    chk(q, 32'h0000a501);
    rd(32'h40);
    chk(q, 32'h0);
    $display("done: reset");
  endtask

  task t_standby;
    wr(`CSP_OFF_SUPPLY, 32'h6);
    wr(`CSP_OFF_PWM, 32'h5);
    wr(`CSP_OFF_WDOG, 32'h2a5);
    wr(`CSP_OFF_CSAMP, 32'h71f);
    chk(eff_csamp, 11'h71f);
    cyc(2);
    chk(eff_sense_analog, 1'b0);
    wr(`CSP_OFF_CSAMP, 32'hf1f);
    cyc(2);
    chk(eff_sense_analog, 1'b0);
    chk({eff_supply, eff_pwm, eff_watchdog}, {4'h6, 4'h5, 11'h2a5});
    drv(1'b1);
    chk({pwm_path_enable, charge_pump_enable}, 2'h3);
    chk(eff_supply, 4'h6);
    $display("done: standby programming");
  endtask

  task t_active;
    wr(`CSP_OFF_ADC, 32'h1b);
    chk(eff_adc, 5'h1b);
    wr(`CSP_OFF_DRIVE, 32'h5a3c96);
    chk(eff_drive, 24'h5a3c96);
    wr(`CSP_OFF_SUPPLY, 32'h9);
    wr(`CSP_OFF_PWM, 32'ha);
    wr(`CSP_OFF_WDOG, 32'h4d5a);
    chk(eff_locked_rotor, 4'h9);
    rd(`CSP_OFF_SUPPLY);
    chk(q, 32'h9);
    cyc(3);
    chk({eff_supply, eff_pwm, eff_watchdog}, {4'h6, 4'h5, 11'h2a5});
    rd(`CSP_OFF_STATUS);
    chk(q, 32'h0000a50c);
    drv(1'b0);
    chk({pwm_path_enable, charge_pump_enable}, 2'h0);
    chk({eff_supply, eff_pwm, eff_watchdog}, {4'h9, 4'ha, 11'h55a});
    $display("done: active");
  endtask

  task t_defer;
    logic [23:0] old;
    logic [23:0] dv;
    old = 24'h5a3c96;
    wr(`CSP_OFF_CTRL, 32'h1);
    // one pass per alignment event: pwm first, then brake
    for (int k = 0; k < 2; k++) begin
      dv = k ? 24'h0f0f0f : 24'h0c3a50;
      wr(`CSP_OFF_DRIVE, {8'h0, dv});
      cyc(3);
      chk(eff_drive, old);
      ev(k == 0, k == 1);
      chk(eff_drive, dv);
      old = dv;
    end
    wr(`CSP_OFF_CTRL, 32'h0);
    $display("done: defer");
  endtask

  task t_otp;
    @(posedge hclk);
    otp_startup_settings <= 8'h3c;
    wr(`CSP_OFF_STATUS, 32'hffffffff);
    wr(32'h100, 32'hf);
    // unmapped write is dropped but still answered okay
    chk(hresp, 1'b0);
    rd(`CSP_OFF_STATUS);
    chk(q, 32'h0000a501);
    rd(`CSP_OFF_SUPPLY);
    chk(q, 32'h9);
    chk(eff_otp_startup, 8'ha5);
    // second power-up picks up the new start-up word
    @(posedge hclk);
    hresetn <= 1'b0;
    otp_sense_analog <= 1'b0;
    cyc(4);
    chk(eff_supply, 4'h0);
    // release on a rising edge like every other input
    @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    chk(eff_otp_startup, 8'h3c);
    chk(eff_sense_analog, 1'b0);
    rd(`CSP_OFF_STATUS);
    chk(q, 32'h00003c01);
    $display("done: otp");
  endtask

  // single exit point for both normal end and watchdog
  task results;
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // whole run is under two hundred cycles, so 2000 cycles means a hang
  initial begin
    #100000;
    errors++;
    results;
  end

  // reset for four cycles, then two idle edges before the first request
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    t_reset;
    t_standby;
    t_active;
    t_defer;
    t_otp;
    results;
  end
endmodule
